/* File: core/led_gray_pkg.sv */
/*
 Shared constants for the grayscale PWM serial link: command word
 layout, timing counts, host register map and host operations.
 Assumes a 200 MHz system clock on both ends.
*/
package led_gray_pkg;
	localparam int NUM_CHANNELS = 12;
	localparam int SECTIONS     = 16;
	localparam int MAX_DEPTH    = 14;
	localparam int CMD_BITS     = 8;
	localparam int CHAIN_BITS   = NUM_CHANNELS * MAX_DEPTH;

	// Command word layout
	localparam int CFG_DEPTH_POS  = 6;
	localparam int CFG_DIVIDE_POS = 4;
	localparam int CFG_SOURCE_BIT = 3;
	localparam int CFG_INVERT_BIT = 2;
	localparam int CFG_GUARD_POS  = 0;
	localparam logic [1:0] GUARD_VALID = 2'h3;
	localparam logic [7:0] CFG_RESET   = 8'h00;

	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_MHZ       = 200;
	localparam int OSC_MHZ       = 10;
	localparam int OSC_DIV       = CLK_MHZ / OSC_MHZ;
	localparam int T_CMD_NS      = 15;
	localparam int TCMD_CYCLES   =
		(T_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_LOW_CYCLES  = 4;
	localparam int SCLK_HIGH_CYCLES = 10;

	// Host register map
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_DATA    = 8'h04;
	localparam logic [7:0] ADDR_LENGTH  = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_CMD_ENTRY,
		OP_LATCH,
		OP_SHIFT
	} host_op_t;
endpackage

/* File: core/led_gray_if.sv */
/*
 Serial link between host controller and PWM device.
 Assumes both ends run on the same clk; the bench joins them.
*/
`timescale 1ns/1ps
interface led_gray_if;
	logic serialClockIn;
	logic serialDataIn;
	logic serialClockChainOut;
	logic serialDataChainOut;

	modport device (
		input  serialClockIn,
		input  serialDataIn,
		output serialClockChainOut,
		output serialDataChainOut
	);
	modport host (
		output serialClockIn,
		output serialDataIn,
		input  serialClockChainOut,
		input  serialDataChainOut
	);
endinterface

/* File: core/led_gray_device.sv */
/*
 Twelve-channel grayscale PWM device with serial front end, command
 mode, single-rise latch, clock selection and section-spread PWM.
 Assumes link inputs synchronous to clk and a host that returns the
 data line low one cycle after each serial clock rise.
*/
// What this block does
// - Spread on-time over 16 equal sections
// - Two data rises in high phase: command mode
// - Shift in 8-bit command word in command mode
// - One data rise latches command, leaves command mode
// - Same single-rise latch loads grayscale values
// - Sample data on serial clock rise
// - Host sends words MSB first
// - Depth field selects 8/10/12/14-bit counter
// - Divide field divides grayscale clock 1/2/4/8
// - Source bit: internal 10 MHz or serial clock
// - Polarity bit inverts PWM outputs
// - Apply command only when guard equals 11
// - Host waits 15 ns before pattern edges
// - Host resends configuration after restart (led_gray_host has no such step; config returns to CFG_RESET)
// - Chained devices all detect each pattern, one cycle apart
// - Grayscale word width follows configured depth
// - Chain: one entry, all data, one latch
// - Period is two to the depth cycles
// - Value N gives N on-cycles per period
`timescale 1ns/1ps
module led_gray_device (
	input  wire logic                    clk,
	input  wire logic                    rst,
	led_gray_if.device                   link,
	output logic [led_gray_pkg::NUM_CHANNELS-1:0] pwmOut,
	output logic                         commandMode,
	output logic [7:0]                   activeConfig
);

	function automatic logic [3:0] depth_bits(input logic [1:0] sel);
		return 4'd8 + {1'b0, sel, 1'b0};
	endfunction

	logic                                  sclkPrev;
	logic                                  dataPrev;
	logic [1:0]                            riseCount;
	logic                                  sampledBit;
	logic [7:0]                            cmdShift;
	logic [led_gray_pkg::CHAIN_BITS-1:0]   grayShift;
	logic [4:0]                            oscCount;
	logic [2:0]                            divCount;
	logic [13:0]                           pwmCount;
	logic                                  chainClock;
	logic                                  chainData;
	wire [led_gray_pkg::NUM_CHANNELS-1:0]  litVec;

	wire sclk = link.serialClockIn;
	wire din  = link.serialDataIn;

	wire sclkRise = sclk & ~sclkPrev;
	wire sclkFall = ~sclk & sclkPrev;
	wire highHold = sclk & sclkPrev;
	wire dataRise = highHold & din & ~dataPrev;

	// Pattern is judged at the end of the high phase
	wire enterCmd = sclkFall && (riseCount >= 2'd2);
	wire latchEvt = sclkFall && (riseCount == 2'd1);
	// A plain bit is committed only when no pattern rode on its pulse
	wire bitDone  = sclkFall && (riseCount == 2'd0);
	wire grayLatch = latchEvt && !commandMode;

	wire [1:0] depthSel  = activeConfig[led_gray_pkg::CFG_DEPTH_POS +: 2];
	wire [1:0] divideSel = activeConfig[led_gray_pkg::CFG_DIVIDE_POS +: 2];
	wire       srcSerial = activeConfig[led_gray_pkg::CFG_SOURCE_BIT];
	wire       invert    = activeConfig[led_gray_pkg::CFG_INVERT_BIT];
	wire [1:0] guard     = cmdShift[led_gray_pkg::CFG_GUARD_POS +: 2];

	wire [3:0]  depthBits  = depth_bits(depthSel);
	wire [3:0]  sectShift  = depthBits - 4'd4;
	wire [13:0] periodLast = 14'((15'h1 << depthBits) - 15'h1);
	wire [13:0] sectMask   = 14'((15'h1 << sectShift) - 15'h1);
	wire [3:0]  section    = 4'(pwmCount >> sectShift);
	wire [13:0] sectPos    = pwmCount & sectMask;

	wire [7:0] chainTop = 8'({4'd0, depthBits} * 8'd12) - 8'd1;
	wire       chainMsb = commandMode ? cmdShift[7] : grayShift[chainTop];

	wire oscTick = (oscCount == 5'(led_gray_pkg::OSC_DIV - 1));
	wire srcTick = srcSerial ? sclkRise : oscTick;
	wire [2:0] divMask = 3'((4'h1 << divideSel) - 4'h1);
	wire gsTick = srcTick && ((divCount & divMask) == divMask);

	assign link.serialClockChainOut = chainClock;
	assign link.serialDataChainOut  = chainData;

	always_ff @(posedge clk) begin
		if (rst) begin
			sclkPrev <= 1'b0;
			dataPrev <= 1'b0;
		end else begin
			sclkPrev <= sclk;
			dataPrev <= din;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			riseCount <= 2'd0;
		end else if (sclkRise) begin
			riseCount <= 2'd0;
		end else if (dataRise && riseCount != 2'd3) begin
			riseCount <= riseCount + 2'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sampledBit <= 1'b0;
		end else if (sclkRise) begin
			sampledBit <= din;
		end
	end

	// MSB arrives first, so it ends up highest in the chain
	always_ff @(posedge clk) begin
		if (rst) begin
			cmdShift  <= 8'h00;
			grayShift <= '0;
		end else if (bitDone && commandMode) begin
			cmdShift <= {cmdShift[6:0], sampledBit};
		end else if (bitDone) begin
			grayShift <= {grayShift[led_gray_pkg::CHAIN_BITS-2:0],
				sampledBit};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			commandMode <= 1'b0;
		end else if (enterCmd) begin
			commandMode <= 1'b1;
		end else if (latchEvt) begin
			commandMode <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			activeConfig <= led_gray_pkg::CFG_RESET;
		end else if (latchEvt && commandMode &&
			guard == led_gray_pkg::GUARD_VALID) begin
			activeConfig <= cmdShift;
		end
	end

	// Pass clock on one cycle late, and high-phase data with it (else the chain's top bit),
	// so every chained device sees the same patterns a fixed lag apart.
	always_ff @(posedge clk) begin
		if (rst) begin
			chainClock <= 1'b0;
			chainData  <= 1'b0;
		end else begin
			chainClock <= sclk;
			chainData  <= highHold ? din : chainMsb;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || oscTick) begin
			oscCount <= 5'd0;
		end else begin
			oscCount <= oscCount + 5'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			divCount <= 3'd0;
		end else if (srcTick) begin
			divCount <= divCount + 3'd1;
		end
	end

	// A shrinking depth may leave the count above the new period
	always_ff @(posedge clk) begin
		if (rst) begin
			pwmCount <= 14'd0;
		end else if (gsTick) begin
			if (pwmCount >= periodLast) begin
				pwmCount <= 14'd0;
			end else begin
				pwmCount <= pwmCount + 14'd1;
			end
		end
	end

	// Channel k takes slot k; the first word sent lands in channel 11.
	// Each section gets N/16 cycles, the first N%16 sections one more.
	for (genvar ch = 0; ch < led_gray_pkg::NUM_CHANNELS; ch++) begin : g_chan
		logic [13:0] level;
		wire [13:0] slot  = 14'(grayShift >> (ch * depthBits));
		wire [13:0] share = {4'd0, level[13:4]} +
			{13'd0, (section < level[3:0])};
		wire        lit   = sectPos < share;

		always_ff @(posedge clk) begin
			if (rst) begin
				level <= 14'd0;
			end else if (grayLatch) begin
				level <= slot & periodLast;
			end
		end

		assign litVec[ch] = lit;
	end

	// One register for all channels keeps a single driver on pwmOut
	always_ff @(posedge clk) begin
		if (rst) begin
			pwmOut <= '0;
		end else begin
			pwmOut <= litVec ^ {led_gray_pkg::NUM_CHANNELS{invert}};
		end
	end

endmodule

/* File: core/led_gray_host.sv */
/*
 Host controller: AHB-Lite slave registers steer a serial engine that
 shifts words MSB first and sends command-entry and latch patterns.
 Assumes a single AHB-Lite master; the device samples on clk too.
*/
`timescale 1ns/1ps
module led_gray_host (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	led_gray_if.host         link
);

	typedef enum logic [1:0] {IDLE, CLK_LOW, CLK_HIGH} host_state_t;

	host_state_t            state;
	led_gray_pkg::host_op_t op;
	logic [15:0]            shiftData;
	logic [3:0]             shiftLength;
	logic [15:0]            shiftReg;
	logic [4:0]             bitsLeft;
	logic [4:0]             phaseCount;
	logic                   writePending;
	logic [7:0]             writeAddr;
	logic                   sclkOut;
	logic                   dataOut;

	wire addrTaken = hsel && htrans[1] && hready;
	wire busy      = (state != IDLE);
	wire ctrlWrite = writePending && writeAddr == led_gray_pkg::ADDR_CONTROL;
	wire [1:0] opReq = hwdata[1:0];
	wire start = ctrlWrite && !busy && opReq != 2'd0;
	wire [15:0] aligned = shiftData << (4'd15 - shiftLength);
	wire lastHigh = phaseCount == 5'(led_gray_pkg::SCLK_HIGH_CYCLES - 1);
	wire lastLow  = phaseCount == 5'(led_gray_pkg::SCLK_LOW_CYCLES - 1);
	wire [4:0] tcmd = 5'(led_gray_pkg::TCMD_CYCLES);

	// Two rises for command entry, one for latch, spaced 2 cycles
	wire patRise = (op == led_gray_pkg::OP_CMD_ENTRY) ?
		(phaseCount == tcmd || phaseCount == tcmd + 5'd2) :
		(op == led_gray_pkg::OP_LATCH && phaseCount == tcmd);

	wire [7:0] readAddr = haddr[7:0];
	wire [31:0] readMux =
		(readAddr == led_gray_pkg::ADDR_DATA)   ? {16'h0, shiftData} :
		(readAddr == led_gray_pkg::ADDR_LENGTH) ? {28'h0, shiftLength} :
		(readAddr == led_gray_pkg::ADDR_STATUS) ? {31'h0, busy} :
		(readAddr == led_gray_pkg::ADDR_CONTROL) ? {30'h0, op} : 32'h0;

	assign link.serialClockIn = sclkOut;
	assign link.serialDataIn  = dataOut;

	always_ff @(posedge clk) begin
		if (rst) begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			hrdata       <= 32'h0;
			writePending <= 1'b0;
			writeAddr    <= 8'h00;
		end else begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			writePending <= addrTaken && hwrite;
			writeAddr    <= haddr[7:0];
			if (addrTaken && !hwrite) begin
				hrdata <= readMux;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shiftData   <= 16'h0;
			shiftLength <= 4'h7;
		end else if (writePending && !busy) begin
			if (writeAddr == led_gray_pkg::ADDR_DATA) begin
				shiftData <= hwdata[15:0];
			end
			if (writeAddr == led_gray_pkg::ADDR_LENGTH) begin
				shiftLength <= hwdata[3:0];
			end
		end
	end

	// Data returns low one cycle after each clock rise so the device
	// can forward the line down a chain without false rises.
	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= IDLE;
			op         <= led_gray_pkg::OP_NONE;
			shiftReg   <= 16'h0;
			bitsLeft   <= 5'd0;
			phaseCount <= 5'd0;
			sclkOut    <= 1'b0;
			dataOut    <= 1'b0;
		end else begin
			case (state)
				IDLE: begin
					phaseCount <= 5'd0;
					if (start) begin
						op       <= led_gray_pkg::host_op_t'(opReq);
						shiftReg <= aligned;
						bitsLeft <= {1'b0, shiftLength} + 5'd1;
						dataOut  <= (opReq == led_gray_pkg::OP_SHIFT) &&
							aligned[15];
						state    <= CLK_LOW;
					end
				end
				CLK_LOW: begin
					phaseCount <= phaseCount + 5'd1;
					if (lastLow) begin
						sclkOut    <= 1'b1;
						phaseCount <= 5'd0;
						state      <= CLK_HIGH;
					end
				end
				CLK_HIGH: begin
					phaseCount <= phaseCount + 5'd1;
					dataOut    <= patRise;
					if (lastHigh) begin
						sclkOut    <= 1'b0;
						phaseCount <= 5'd0;
						if (op == led_gray_pkg::OP_SHIFT &&
							bitsLeft > 5'h01) begin
							bitsLeft <= bitsLeft - 5'd1;
							shiftReg <= {shiftReg[14:0], 1'b0};
							dataOut  <= shiftReg[14];
							state    <= CLK_LOW;
						end else begin
							dataOut <= 1'b0;
							state   <= IDLE;
						end
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

endmodule

/* File: dv/led_gray_monitor.sv */
/*
 Link and mode checks between the host and the device.
 Assumes every signal is sampled on clk; the bench instantiates it.
*/
`timescale 1ns/1ps
module led_gray_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       serialClockIn,
	input wire logic       serialDataIn,
	input wire logic       serialClockChainOut,
	input wire logic       serialDataChainOut,
	input wire logic       commandMode,
	input wire logic [7:0] activeConfig
);
	logic       prevClk;
	logic       prevData;
	logic       bitSeen;
	logic [1:0] riseCnt;
	logic [7:0] shiftReg;
	wire        clkRise = serialClockIn & ~prevClk;
	wire        clkFall = ~serialClockIn & prevClk;
	wire        dataRise = serialDataIn & ~prevData &
		serialClockIn & prevClk;
	wire        guardOk = shiftReg[1:0] == led_gray_pkg::GUARD_VALID;

	// Rises in the clock's rising cycle are not counted, as in the device
	always_ff @(posedge clk) begin
		prevClk <= rst ? 1'b0 : serialClockIn;
		prevData <= rst ? 1'b0 : serialDataIn;
		if (clkRise) begin
			riseCnt <= 2'h0;
			bitSeen <= serialDataIn;
		end else if (dataRise && riseCnt != 2'h2) begin
			riseCnt <= riseCnt + 2'h1;
		end
		if (clkFall && riseCnt == 2'h0) begin
			shiftReg <= {shiftReg[6:0], bitSeen};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_entry;
		clkFall && riseCnt == 2'h2;
	endsequence
	sequence s_latch;
		clkFall && riseCnt == 2'h1;
	endsequence

	a_chain_clock_lag: assert property (
		serialClockChainOut == $past(serialClockIn))
		else $error("chain clock lag wrong");
	// The device forwards a high-phase data bit one cycle later
	a_chain_data_pass: assert property (
		serialClockIn && prevClk |=>
		serialDataChainOut == $past(serialDataIn))
		else $error("chain data wrong");
	a_entry_mode: assert property (
		s_entry |=> commandMode)
		else $error("no command mode");
	a_latch_exit: assert property (
		s_latch |=> !commandMode)
		else $error("command mode kept");
	a_cmd_apply: assert property (
		s_latch ##0 commandMode && guardOk |=>
		activeConfig == $past(shiftReg))
		else $error("command not applied");
	a_guard_refuse: assert property (
		s_latch ##0 commandMode && !guardOk |=> $stable(activeConfig))
		else $error("bad guard applied");
	a_config_hold: assert property (
		!(clkFall && commandMode) |=> $stable(activeConfig))
		else $error("config changed");
	a_mode_hold: assert property (
		commandMode && !clkFall |=> commandMode)
		else $error("command mode lost");
	a_pattern_delay: assert property (
		$rose(serialDataIn) && serialClockIn |->
		$past(serialClockIn, 3))
		else $error("pattern too early");
endmodule

/* File: dv/led_gray_pwm_serial_cfg_tb.sv */
/*
 Bench: an AHB-Lite master steers the host, which drives the device.
 Assumes the package and the link interface compile first.
*/
`timescale 1ns/1ps
module led_gray_pwm_serial_cfg_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [11:0] pwmOut;
	logic        commandMode;
	logic [7:0]  activeConfig;
	int          fails = 0;
	int          numChecks = 0;
	int          n0;
	int          n11;
	int          r0;

	led_gray_if link ();
	led_gray_host led_gray_host_i (.clk(clk), .rst(rst), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .link(link));
	led_gray_device led_gray_device_i (.clk(clk), .rst(rst), .link(link),
		.pwmOut(pwmOut), .commandMode(commandMode),
		.activeConfig(activeConfig));
	led_gray_monitor led_gray_monitor_i (.clk(clk), .rst(rst),
		.serialClockIn(link.serialClockIn),
		.serialDataIn(link.serialDataIn),
		.serialClockChainOut(link.serialClockChainOut),
		.serialDataChainOut(link.serialDataChainOut),
		.commandMode(commandMode), .activeConfig(activeConfig));

	always #2.5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic op(input logic [1:0] c, input logic [15:0] w,
		input logic [3:0] len);
		logic [31:0] r;
		ahb(1'b1, led_gray_pkg::ADDR_DATA, {16'h0, w}, r);
		ahb(1'b1, led_gray_pkg::ADDR_LENGTH, {28'h0, len}, r);
		ahb(1'b1, led_gray_pkg::ADDR_CONTROL, {30'h0, c}, r);
		r = 32'h1;
		while (r[0] !== 1'b0)
			ahb(1'b0, led_gray_pkg::ADDR_STATUS, 32'h0, r);
		// Device mode settles one cycle after the clock falls
		repeat (2) @(posedge clk);
	endtask

	task automatic set_cfg(input logic [7:0] w);
		op(2'h1, 16'h0, 4'h0);
		op(2'h3, {8'h0, w}, 4'h7);
		op(2'h2, 16'h0, 4'h0);
	endtask

	// First word shifted lands in channel 11
	task automatic load_gray(input logic [3:0] len,
		input logic [15:0] v0, input logic [15:0] v11);
		for (int i = 11; i >= 0; i--)
			op(2'h3, i == 0 ? v0 : (i == 11 ? v11 : 16'h0), len);
		op(2'h2, 16'h0, 4'h0);
	endtask

	// One settling period first; a new level takes effect the cycle after the latch
	task automatic measure(input int period);
		logic last;
		n0 = 0;
		n11 = 0;
		r0 = 0;
		repeat (period + 1) @(posedge clk);
		last = pwmOut[0];
		repeat (period) begin
			@(posedge clk);
			n0 += (pwmOut[0] === 1'b1);
			n11 += (pwmOut[11] === 1'b1);
			r0 += (pwmOut[0] === 1'b1 && last === 1'b0);
			last = pwmOut[0];
		end
	endtask

	task automatic t_reset();
		logic [31:0] r;
		check(commandMode, 1'b0);
		check(activeConfig, led_gray_pkg::CFG_RESET);
		ahb(1'b0, led_gray_pkg::ADDR_LENGTH, 32'h0, r);
		check(r, 32'h7);
		ahb(1'b1, 8'h10, 32'hff, r);
		ahb(1'b0, 8'h10, 32'h0, r);
		check(r, 32'h0);
		check(hresp, 1'b0);
	endtask

	task automatic t_command();
		op(2'h1, 16'h0, 4'h0);
		check(commandMode, 1'b1);
		op(2'h3, 16'h0042, 4'h7);
		op(2'h2, 16'h0, 4'h0);
		check(commandMode, 1'b0);
		check(activeConfig, 8'h00);
		set_cfg(8'h43);
		check(activeConfig, 8'h43);
	endtask

	// 10-bit depth, 20 clk per grayscale tick
	task automatic t_ten_bit();
		load_gray(4'h9, 16'h0014, 16'h0200);
		measure(1024 * 20);
		check(n0, 20 * 20);
		check(n11, 512 * 20);
		check(r0, 16);
	endtask

	// 8-bit depth, divide by 2, inverted outputs
	task automatic t_eight_inverted();
		set_cfg(8'h17);
		check(activeConfig, 8'h17);
		load_gray(4'h7, 16'h0014, 16'h0080);
		measure(256 * 40);
		check(n0, 10240 - 20 * 40);
		check(n11, 10240 - 128 * 40);
		check(r0, 16);
	endtask

	// Serial clock as grayscale source: an idle link freezes the PWM
	task automatic t_serial_source();
		set_cfg(8'h0b);
		check(activeConfig, 8'h0b);
		measure(1000);
		check(r0, 0);
	endtask

	task automatic wrap_up();
		$display("checks=%0d fails=%0d", numChecks, fails);
		if (fails == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_command();
		t_ten_bit();
		t_eight_inverted();
		t_serial_source();
		wrap_up();
	end

	// About 90k clk; the scenarios need roughly 70k
	initial begin
		#450000;
		fails++;
		wrap_up();
	end
endmodule
